// ### hw/pin_remap_pkg.sv
// Purpose: Shared constants and carriers for the remappable pin select multiplexer.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Pin count is small and fixed; offsets and codes are named here once, inner members of a range only by its base or ends.
package pin_remap_pkg;

	localparam int NUM_PINS = 4;
	localparam int SEL_W    = 6;
	localparam int IN_SEL_W = 8;
	localparam int NUM_OUT  = 20;

	// Register byte offsets.
	localparam logic [11:0] OFS_IRQ_ONE_SEL  = 12'h000;
	localparam logic [11:0] OFS_OUT_SEL_BASE = 12'h010;
	localparam logic [11:0] OFS_ANALOG_SEL   = 12'h020;
	localparam logic [11:0] OFS_DIRECTION    = 12'h024;
	localparam logic [11:0] OFS_OUT_LATCH    = 12'h028;
	localparam logic [11:0] OFS_PIN_LEVEL    = 12'h02C;
	localparam logic [11:0] OFS_DEDICATED_EN = 12'h030;

	// Field positions and reset values.
	localparam int          IRQ_SEL_LSB     = 8;
	localparam logic [15:0] IRQ_SEL_RESET   = 16'h0000;
	localparam logic [5:0]  OUT_SEL_RESET   = 6'h00;
	localparam logic [3:0]  ANALOG_RESET    = 4'hF;
	localparam logic [3:0]  DIRECTION_RESET = 4'hF;
	localparam logic [3:0]  LATCH_RESET     = 4'h0;
	localparam logic [3:0]  DEDICATED_RESET = 4'h0;

	// Output function codes.
	localparam logic [5:0] OSEL_DEFAULT    = 6'h00;
	localparam logic [5:0] OSEL_UART_ONE   = 6'h01;
	localparam logic [5:0] OSEL_UART_TWO   = 6'h03;
	localparam logic [5:0] OSEL_SPI_DATA   = 6'h08;
	localparam logic [5:0] OSEL_SPI_CLK    = 6'h09;
	localparam logic [5:0] OSEL_SPI_SEL    = 6'h0A;
	localparam logic [5:0] OSEL_CAN_TX     = 6'h0E;
	localparam logic [5:0] OSEL_COMPARE_1  = 6'h10;
	localparam logic [5:0] OSEL_COMPARE_4  = 6'h13;
	localparam logic [5:0] OSEL_COMPTR_1   = 6'h18;
	localparam logic [5:0] OSEL_COMPTR_3   = 6'h1A;
	localparam logic [5:0] OSEL_PWM_SYNC   = 6'h2D;
	localparam logic [5:0] OSEL_REF_CLOCK  = 6'h31;
	localparam logic [5:0] OSEL_COMPTR_4   = 6'h32;
	localparam logic [5:0] OSEL_COMPTR_5   = 6'h33;
	localparam logic [5:0] OSEL_SENT_FIRST = 6'h39;
	localparam logic [5:0] OSEL_SENT_2ND   = 6'h3A;

	// Input select codes.
	localparam logic [7:0] ISEL_GROUND   = 8'h00;
	localparam logic [7:0] ISEL_COMPTR_1 = 8'h01;
	localparam logic [7:0] ISEL_PIN_BASE = 8'h02;
	localparam logic [7:0] ISEL_TOP_VIRT = 8'hB5;

	// Remappable peripheral outputs gathered into one carrier.
	typedef struct packed {
		logic       uart_one_tx_out;
		logic       uart_two_tx_out;
		logic       spi_two_data_out;
		logic       spi_two_clock_out;
		logic       spi_two_select_out;
		logic       can_one_tx_out;
		logic [3:0] compare_out;
		logic [4:0] comparator_out;
		logic       pwm_timebase_sync_out;
		logic       reference_clock_out;
		logic       sent_tx_first;
		logic       sent_tx_second;
	} periph_out_t;

	// Dedicated function drive per pin.
	typedef struct packed {
		logic [NUM_PINS-1:0] out_en;
		logic [NUM_PINS-1:0] out_val;
	} dedicated_t;

endpackage

// ### hw/out_func_select.sv
// Purpose: Decodes one pin's 6-bit output function code into a single drive bit.
// Assumes: Peripheral outputs are synchronous to the system clock.
// Notes:   Purely combinational; one instance per remappable pin.
module out_func_select (
	input  wire logic [5:0]               code,     // Output function select code
	input  wire pin_remap_pkg::periph_out_t periph, // Remappable peripheral outputs
	output logic                          active,   // A remappable function is selected
	output logic                          value     // Selected function level
);

	always_comb begin
		active = 1'b1;
		value  = 1'b0;
		if (code == pin_remap_pkg::OSEL_UART_ONE) begin
			value = periph.uart_one_tx_out;
		end else if (code == pin_remap_pkg::OSEL_UART_TWO) begin
			value = periph.uart_two_tx_out;
		end else if (code == pin_remap_pkg::OSEL_SPI_DATA) begin
			value = periph.spi_two_data_out;
		end else if (code == pin_remap_pkg::OSEL_SPI_CLK) begin
			value = periph.spi_two_clock_out;
		end else if (code == pin_remap_pkg::OSEL_SPI_SEL) begin
			value = periph.spi_two_select_out;
		end else if (code == pin_remap_pkg::OSEL_CAN_TX) begin
			value = periph.can_one_tx_out;
		end else if (code >= pin_remap_pkg::OSEL_COMPARE_1 && code <= pin_remap_pkg::OSEL_COMPARE_4) begin
			value = periph.compare_out[code[1:0]];
		end else if (code >= pin_remap_pkg::OSEL_COMPTR_1 && code <= pin_remap_pkg::OSEL_COMPTR_3) begin
			value = periph.comparator_out[{1'b0, code[1:0]}];
		end else if (code == pin_remap_pkg::OSEL_COMPTR_4) begin
			value = periph.comparator_out[3];
		end else if (code == pin_remap_pkg::OSEL_COMPTR_5) begin
			value = periph.comparator_out[4];
		end else if (code == pin_remap_pkg::OSEL_PWM_SYNC) begin
			value = periph.pwm_timebase_sync_out;
		end else if (code == pin_remap_pkg::OSEL_REF_CLOCK) begin
			value = periph.reference_clock_out;
		end else if (code == pin_remap_pkg::OSEL_SENT_FIRST) begin
			value = periph.sent_tx_first;
		end else if (code == pin_remap_pkg::OSEL_SENT_2ND) begin
			value = periph.sent_tx_second;
		end else begin
			// Null code and every unassigned code leave the pin to its port function.
			active = 1'b0;
		end
	end

endmodule

// ### hw/remappable_pin_select_mux.sv
// Purpose: Peripheral pin remap multiplexer with APB register access.
// Assumes: One clock; pin inputs synchronous to clk; APB master per the AMBA protocol.
// Notes:   Four remappable pins; the gated input path of each of the four pins feeds the interrupt select.
module remappable_pin_select_mux (
	input  wire logic                          clk,            // System clock, 20 MHz
	input  wire logic                          rst_n,          // Asynchronous reset, active low
	input  wire logic                          psel,           // APB select
	input  wire logic                          penable,        // APB enable
	input  wire logic                          pwrite,         // APB write
	input  wire logic [11:0]                   paddr,          // APB byte address
	input  wire logic [31:0]                   pwdata,         // APB write data
	output logic      [31:0]                   prdata,         // APB read data
	output logic                               pready,         // APB ready
	output logic                               pslverr,        // APB error
	input  wire pin_remap_pkg::periph_out_t    periph,         // Remappable peripheral outputs
	input  wire pin_remap_pkg::dedicated_t     dedicated,      // Dedicated output functions
	input  wire logic [3:0]                    remap_pin_in,   // Pin input levels
	output logic      [3:0]                    remap_pin_out,  // Pin output levels
	output logic      [3:0]                    remap_pin_oe,   // Pin output enables
	output logic      [3:0]                    digital_in,     // Gated digital input levels
	output logic                               ext_irq_one_in  // Selected interrupt one source
);

	localparam int NP = pin_remap_pkg::NUM_PINS;

	logic [7:0]    ext_irq_one_pin_sel_r;
	logic [5:0]    pin_output_func_sel_r [NP];
	logic [NP-1:0] analog_select_reg_r;
	logic [NP-1:0] pin_direction_reg_r;
	logic [NP-1:0] output_latch_reg_r;
	logic [NP-1:0] ded_enable_r;
	logic [NP-1:0] pin_level_reg_r;
	logic [NP-1:0] remap_active;
	logic [NP-1:0] remap_value;
	logic [NP-1:0] pin_out_nxt;
	logic [NP-1:0] pin_oe_nxt;
	logic [NP-1:0] dig_in_nxt;
	logic          irq_nxt;
	logic [31:0]   rdata_nxt;
	logic          err_nxt;
	logic          wr_en;
	logic          rd_en;

	// Single-cycle access phase: no wait states.
	assign pready = 1'b1;
	assign wr_en  = psel && penable && pwrite;
	// A read is recognised in its setup cycle so that its data can be registered ahead of the access phase.
	assign rd_en  = psel && !penable && !pwrite;

	// Every mapping register is written independently; nothing cross-checks them.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_irq_one_pin_sel_r <= pin_remap_pkg::IRQ_SEL_RESET[15:8];
		end else if (wr_en && paddr == pin_remap_pkg::OFS_IRQ_ONE_SEL) begin
			ext_irq_one_pin_sel_r <= pwdata[15:8];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			analog_select_reg_r <= pin_remap_pkg::ANALOG_RESET;
			pin_direction_reg_r <= pin_remap_pkg::DIRECTION_RESET;
			output_latch_reg_r  <= pin_remap_pkg::LATCH_RESET;
			ded_enable_r        <= pin_remap_pkg::DEDICATED_RESET;
		end else if (wr_en) begin
			if (paddr == pin_remap_pkg::OFS_ANALOG_SEL) begin
				analog_select_reg_r <= pwdata[NP-1:0];
			end else if (paddr == pin_remap_pkg::OFS_DIRECTION) begin
				pin_direction_reg_r <= pwdata[NP-1:0];
			end else if (paddr == pin_remap_pkg::OFS_OUT_LATCH) begin
				output_latch_reg_r <= pwdata[NP-1:0];
			end else if (paddr == pin_remap_pkg::OFS_DEDICATED_EN) begin
				ded_enable_r <= pwdata[NP-1:0];
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NP; g++) begin : g_pin
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					pin_output_func_sel_r[g] <= pin_remap_pkg::OUT_SEL_RESET;
				end else if (wr_en && paddr == pin_remap_pkg::OFS_OUT_SEL_BASE + 12'(4 * g)) begin
					pin_output_func_sel_r[g] <= pwdata[5:0];
				end
			end

			// The same peripheral bus feeds every pin decoder, so one function may reach many pins.
			out_func_select u_sel (
				.code   (pin_output_func_sel_r[g]),
				.periph (periph),
				.active (remap_active[g]),
				.value  (remap_value[g])
			);

			// Fixed priority: dedicated output, then remappable output, then port latch.
			always_comb begin
				if (dedicated.out_en[g] && ded_enable_r[g]) begin
					pin_out_nxt[g] = dedicated.out_val[g];
					pin_oe_nxt[g]  = 1'b1;
				end else if (remap_active[g]) begin
					pin_out_nxt[g] = remap_value[g];
					pin_oe_nxt[g]  = 1'b1;
				end else begin
					pin_out_nxt[g] = output_latch_reg_r[g];
					pin_oe_nxt[g]  = !pin_direction_reg_r[g];
				end
			end

			// Only the analog bit gates the input buffer; output drive is left untouched.
			assign dig_in_nxt[g] = remap_pin_in[g] & !analog_select_reg_r[g];
		end
	endgenerate

	// One mux result per pin means exactly one driver reaches each pin.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			remap_pin_out <= 4'h0;
			remap_pin_oe  <= 4'h0;
		end else begin
			remap_pin_out <= pin_out_nxt;
			remap_pin_oe  <= pin_oe_nxt;
		end
	end

	// Inputs are sampled without regard to the drive, so the pin may be read while driven.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_level_reg_r <= 4'h0;
			digital_in      <= 4'h0;
		end else begin
			pin_level_reg_r <= dig_in_nxt;
			digital_in      <= dig_in_nxt;
		end
	end

	// Codes beyond the pins present, up to the top virtual code, read as ground.
	always_comb begin
		if (ext_irq_one_pin_sel_r == pin_remap_pkg::ISEL_GROUND) begin
			irq_nxt = 1'b0;
		end else if (ext_irq_one_pin_sel_r == pin_remap_pkg::ISEL_COMPTR_1) begin
			irq_nxt = periph.comparator_out[0];
		end else if (ext_irq_one_pin_sel_r >= pin_remap_pkg::ISEL_PIN_BASE
		             && ext_irq_one_pin_sel_r < pin_remap_pkg::ISEL_PIN_BASE + 8'(NP)) begin
			irq_nxt = dig_in_nxt[2'(ext_irq_one_pin_sel_r - pin_remap_pkg::ISEL_PIN_BASE)];
		end else begin
			irq_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_irq_one_in <= 1'b0;
		end else begin
			ext_irq_one_in <= irq_nxt;
		end
	end

	// Read mux; reserved bits read as zero and unmapped addresses answer with an error.
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		err_nxt   = 1'b0;
		if (paddr == pin_remap_pkg::OFS_IRQ_ONE_SEL) begin
			rdata_nxt[15:8] = ext_irq_one_pin_sel_r;
		end else if (paddr == pin_remap_pkg::OFS_ANALOG_SEL) begin
			rdata_nxt[NP-1:0] = analog_select_reg_r;
		end else if (paddr == pin_remap_pkg::OFS_DIRECTION) begin
			rdata_nxt[NP-1:0] = pin_direction_reg_r;
		end else if (paddr == pin_remap_pkg::OFS_OUT_LATCH) begin
			rdata_nxt[NP-1:0] = output_latch_reg_r;
		end else if (paddr == pin_remap_pkg::OFS_PIN_LEVEL) begin
			rdata_nxt[NP-1:0] = pin_level_reg_r;
		end else if (paddr == pin_remap_pkg::OFS_DEDICATED_EN) begin
			rdata_nxt[NP-1:0] = ded_enable_r;
		end else if (paddr >= pin_remap_pkg::OFS_OUT_SEL_BASE
		             && paddr < pin_remap_pkg::OFS_OUT_SEL_BASE + 12'(4 * NP) && paddr[1:0] == 2'h0) begin
			rdata_nxt[5:0] = pin_output_func_sel_r[2'(paddr[11:2] - pin_remap_pkg::OFS_OUT_SEL_BASE[11:2])];
		end else begin
			err_nxt = 1'b1;
		end
	end

	// Read data are captured at the end of the setup cycle, so prdata comes from a flip-flop
	// without a wait state; outside a read access the bus shows zero.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= rdata_nxt;
		end else begin
			prdata <= 32'h0000_0000;
		end
	end

	assign pslverr = psel && penable && err_nxt;

endmodule

// ### test/pin_remap_asserts.sv
// Purpose: Port-level assertions for the remappable pin select multiplexer.
// Assumes: Zero-wait APB slave; pin outputs are registered one edge after their cause.
// Notes:   Three registers are shadowed from APB writes so outputs can be tied to them.
module pin_remap_asserts (
	input wire logic                       clk,            // System clock
	input wire logic                       rst_n,          // Reset, active low
	input wire logic                       psel,           // APB select
	input wire logic                       penable,        // APB enable
	input wire logic                       pwrite,         // APB write
	input wire logic [11:0]                paddr,          // APB address
	input wire logic [31:0]                pwdata,         // APB write data
	input wire logic [31:0]                prdata,         // APB read data
	input wire logic                       pready,         // APB ready
	input wire logic                       pslverr,        // APB error
	input wire pin_remap_pkg::periph_out_t periph,         // Peripheral outputs
	input wire pin_remap_pkg::dedicated_t  dedicated,      // Dedicated drive
	input wire logic [3:0]                 remap_pin_in,   // Pin levels
	input wire logic [3:0]                 remap_pin_out,  // Pin drive
	input wire logic [3:0]                 remap_pin_oe,   // Pin enable
	input wire logic [3:0]                 digital_in,     // Gated inputs
	input wire logic                       ext_irq_one_in  // Interrupt source
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       wr;
	logic       rd;
	logic [3:0] ana_s;
	logic [3:0] ded_s;
	logic [7:0] irq_s;
	logic [3:0] ded_on;
	logic [3:0] ded_val;
	logic       cmp_one;
	assign wr      = psel && penable && pwrite && pready;
	assign rd      = psel && penable && !pwrite;
	assign ded_on  = dedicated.out_en & ded_s;
	assign ded_val = dedicated.out_val;
	assign cmp_one = periph.comparator_out[0];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ana_s <= pin_remap_pkg::ANALOG_RESET;
			ded_s <= 4'h0;
			irq_s <= 8'h00;
		end else if (wr) begin
			if (paddr == pin_remap_pkg::OFS_ANALOG_SEL)
				ana_s <= pwdata[3:0];
			if (paddr == pin_remap_pkg::OFS_DEDICATED_EN)
				ded_s <= pwdata[3:0];
			if (paddr == pin_remap_pkg::OFS_IRQ_ONE_SEL)
				irq_s <= pwdata[15:8];
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	chk_analog_gate: assert property (digital_in == ($past(remap_pin_in) & ~$past(ana_s)))
		else $error("digital input not gated by analog select");
	chk_reset_quiet: assert property ($rose(rst_n) |-> remap_pin_oe == 4'h0 && digital_in == 4'h0)
		else $error("pins not quiet after reset");
	chk_dedicated_wins: assert property ((remap_pin_oe & $past(ded_on)) == $past(ded_on))
		else $error("dedicated output not enabled on its pin");
	chk_dedicated_value: assert property (((remap_pin_out ^ $past(ded_val)) & $past(ded_on)) == 4'h0)
		else $error("dedicated pin driven by another source");
	chk_irq_ground: assert property ($past(irq_s) == 8'h00 |-> !ext_irq_one_in)
		else $error("grounded interrupt select not low");
	chk_irq_comp: assert property ($past(irq_s) == 8'h01 |-> ext_irq_one_in == $past(cmp_one))
		else $error("interrupt select does not follow comparator one");
	chk_irq_read: assert property (rd && paddr == 12'h000 |-> prdata == {16'h0, irq_s, 8'h00})
		else $error("interrupt select read back wrong");
	chk_sel_width: assert property (rd && paddr[11:4] == 8'h01 |-> prdata[31:6] == 26'h0)
		else $error("output select wider than six bits");
endmodule

bind remappable_pin_select_mux pin_remap_asserts u_chk (
	.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph(periph),
	.dedicated(dedicated), .remap_pin_in(remap_pin_in), .remap_pin_out(remap_pin_out),
	.remap_pin_oe(remap_pin_oe), .digital_in(digital_in), .ext_irq_one_in(ext_irq_one_in)
);

// ### test/periph_model.sv
// Purpose: Stand-in for the on-chip peripherals and the external pin levels.
// Assumes: Peripheral outputs change on the system clock.
// Notes:   The pattern changes every cycle, so a stale selection cannot pass.
module periph_model (
	input  wire logic                  clk,     // System clock
	input  wire logic                  rst_n,   // Reset, active low
	input  wire logic                  hold,    // Freeze the pin levels
	output pin_remap_pkg::periph_out_t periph,  // Peripheral output levels
	output logic [3:0]                 pin_lvl  // Levels at the pins
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [22:0] lfsr_r;
	assign periph = lfsr_r[18:0];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			lfsr_r <= 23'h05A5A5;
		else
			lfsr_r <= {lfsr_r[21:0], lfsr_r[22] ^ lfsr_r[17]};
	end
	// Holding lets a slow external source settle before the interrupt path samples it.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pin_lvl <= 4'hA;
		else if (!hold)
			pin_lvl <= lfsr_r[22:19];
	end
endmodule

// ### test/remappable_pin_select_mux_tb_top.sv
// Purpose: Self-checking bench for the remappable pin select multiplexer.
// Assumes: Zero-wait APB slave; pin outputs follow their cause by one edge.
// Notes:   Expected pin levels come from register mirrors kept by the bench.
module remappable_pin_select_mux_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                       clk, rst_n, psel, penable, pwrite, pready, pslverr, irq_in, hold;
	logic [11:0]                paddr;
	logic [31:0]                pwdata, prdata;
	pin_remap_pkg::periph_out_t periph;
	pin_remap_pkg::dedicated_t  dedicated;
	logic [3:0]                 pin_in, pin_out, pin_oe, dig_in, ana, dir, lat, den;
	logic [7:0]                 isel;
	logic [5:0]                 code [4];
	int                         fail_count, checked;
	remappable_pin_select_mux DUT (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph(periph),
		.dedicated(dedicated), .remap_pin_in(pin_in), .remap_pin_out(pin_out), .remap_pin_oe(pin_oe),
		.digital_in(dig_in), .ext_irq_one_in(irq_in));
	periph_model u_model (.clk(clk), .rst_n(rst_n), .hold(hold), .periph(periph), .pin_lvl(pin_in));
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] rd, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] d);
		logic [31:0] rd;
		logic        e;
		apb(1'b1, a, d, rd, e);
		chk("write_err", 32'(e), 32'h0);
	endtask
	task automatic wr_all();
		for (int i = 0; i < 4; i++)
			wr(pin_remap_pkg::OFS_OUT_SEL_BASE + 12'(4 * i), 32'(code[i]));
		wr(pin_remap_pkg::OFS_ANALOG_SEL, 32'(ana));
		wr(pin_remap_pkg::OFS_DIRECTION, 32'(dir));
		wr(pin_remap_pkg::OFS_OUT_LATCH, 32'(lat));
		wr(pin_remap_pkg::OFS_DEDICATED_EN, 32'(den));
		wr(pin_remap_pkg::OFS_IRQ_ONE_SEL, {16'h0, isel, 8'h00});
	endtask
	task automatic readback();
		logic [31:0] rd, x;
		logic        e;
		for (int a = 0; a < 32'h38; a += 4) begin
			apb(1'b0, 12'(a), 32'h0, rd, e);
			case (12'(a))
				pin_remap_pkg::OFS_IRQ_ONE_SEL:  x = {16'h0, isel, 8'h00};
				pin_remap_pkg::OFS_ANALOG_SEL:   x = 32'(ana);
				pin_remap_pkg::OFS_DIRECTION:    x = 32'(dir);
				pin_remap_pkg::OFS_OUT_LATCH:    x = 32'(lat);
				pin_remap_pkg::OFS_DEDICATED_EN: x = 32'(den);
				default:                         x = (a >= 32'h10 && a < 32'h20) ? 32'(code[a[3:2]]) : 32'h0;
			endcase
			chk("reg_read", rd, x);
			chk("reg_err", 32'(e), 32'(a inside {32'h4, 32'h8, 32'hC, 32'h34}));
		end
	endtask
	function automatic logic [1:0] exp_sel(logic [5:0] c, pin_remap_pkg::periph_out_t p);
		case (c)
			6'h01:                      return {1'b1, p.uart_one_tx_out};
			6'h03:                      return {1'b1, p.uart_two_tx_out};
			6'h08:                      return {1'b1, p.spi_two_data_out};
			6'h09:                      return {1'b1, p.spi_two_clock_out};
			6'h0A:                      return {1'b1, p.spi_two_select_out};
			6'h0E:                      return {1'b1, p.can_one_tx_out};
			6'h10, 6'h11, 6'h12, 6'h13: return {1'b1, p.compare_out[c[1:0]]};
			6'h18, 6'h19, 6'h1A:        return {1'b1, p.comparator_out[c[1:0]]};
			6'h32, 6'h33:               return {1'b1, p.comparator_out[{2'b00, c[0]} + 3'h3]};
			6'h2D:                      return {1'b1, p.pwm_timebase_sync_out};
			6'h31:                      return {1'b1, p.reference_clock_out};
			6'h39:                      return {1'b1, p.sent_tx_first};
			6'h3A:                      return {1'b1, p.sent_tx_second};
			default:                    return 2'b00;
		endcase
	endfunction
	task automatic pins_chk();
		pin_remap_pkg::periph_out_t p;
		pin_remap_pkg::dedicated_t  d;
		logic [3:0]                 lv, eo, ev, g;
		logic [1:0]                 s;
		logic                       q;
		@(negedge clk);
		p = periph;
		d = dedicated;
		lv = pin_in;
		@(negedge clk);
		g = lv & ~ana;
		for (int i = 0; i < 4; i++) begin
			s = exp_sel(code[i], p);
			eo[i] = (d.out_en[i] & den[i]) | s[1] | ~dir[i];
			ev[i] = (d.out_en[i] & den[i]) ? d.out_val[i] : (s[1] ? s[0] : lat[i]);
		end
		q = (isel == 8'h01) ? p.comparator_out[0] : (isel inside {[2:5]}) ? g[isel[1:0] - 2'h2] : 1'b0;
		chk("pin_oe", 32'(pin_oe), 32'(eo));
		chk("pin_out", 32'(pin_out & eo), 32'(ev & eo));
		chk("digital_in", 32'(dig_in), 32'(g));
		chk("irq_src", 32'(irq_in), 32'(q));
	endtask
	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		{ana, dir, lat, den, isel} = {4'hF, 4'hF, 4'h0, 4'h0, 8'h00};
		code = '{default: 6'h00};
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		print_verdict();
	end
	initial begin
		logic [31:0] rd;
		logic        e;
		{psel, penable, pwrite, hold, rst_n} = 5'h00;
		{paddr, pwdata, dedicated} = 52'h0;
		{fail_count, checked} = 64'h0;
		isel = 8'($urandom(40788));
		do_reset();
		pins_chk();
		readback();
		apb(1'b1, 12'h034, 32'hFFFFFFFF, rd, e);
		chk("unmapped_err", 32'(e), 32'h1);
		wr(pin_remap_pkg::OFS_PIN_LEVEL, 32'hFFFFFFFF);
		wr(pin_remap_pkg::OFS_IRQ_ONE_SEL, 32'hFFFFFFFF);
		isel = 8'hFF;
		dir = 4'($urandom);
		lat = 4'($urandom);
		// Every code on all four pins at once shows one source fanning out to many pins.
		for (int c = 0; c < 64; c++) begin
			code = '{default: 6'(c)};
			wr_all();
			pins_chk();
		end
		readback();
		repeat (40) begin
			foreach (code[i])
				code[i] = 6'($urandom);
			{ana, dir, lat, den} = 16'($urandom);
			isel = ($urandom_range(0, 7) == 7) ? 8'hB5 : 8'($urandom_range(0, 5));
			@(posedge clk);
			dedicated <= 8'($urandom);
			hold <= 1'($urandom);
			wr_all();
			pins_chk();
		end
		do_reset();
		pins_chk();
		readback();
		print_verdict();
	end
endmodule
